// ==== core/odgc_defines.vh ====
// constants for the clock output driver gating control block
// included by the driver control and divider modules; definitions only
`ifndef ODGC_DEFINES_VH
`define ODGC_DEFINES_VH

// register addresses on the internal configuration port
`define ODGC_ADDR_GATE      16'h0102
`define ODGC_ADDR_ENDIV     16'h0103
`define ODGC_ADDR_FORMAT    16'h0104
`define ODGC_ADDR_AMPCM     16'h0105

// field positions, global gate register
`define ODGC_GATE_BIT       0
// field positions, enable and divider register
`define ODGC_PDN_BIT        0
`define ODGC_OE_BIT         1
`define ODGC_FORCE_BIT      2
`define ODGC_BYP_BIT        3
// field positions, format register
`define ODGC_FMT_HI         2
`define ODGC_FMT_LO         0
`define ODGC_SYNC_BIT       3
`define ODGC_DIS_HI         5
`define ODGC_DIS_LO         4
`define ODGC_DRV_HI         7
`define ODGC_DRV_LO         6
// field positions, amplitude and common mode register
`define ODGC_CM_HI          3
`define ODGC_CM_LO          0
`define ODGC_AMPL_HI        6
`define ODGC_AMPL_LO        4

// reset values
`define ODGC_RST_GATE       8'h00
`define ODGC_RST_ENDIV      8'h00
`define ODGC_RST_FORMAT     8'h00
`define ODGC_RST_AMPCM      8'h00

// writable bit masks, other bits read as zero
`define ODGC_MASK_GATE      8'h01
`define ODGC_MASK_ENDIV     8'h0f
`define ODGC_MASK_FORMAT    8'hff
`define ODGC_MASK_AMPCM     8'h7f

// output format codes
`define ODGC_FMT_DIFF       3'h1
`define ODGC_FMT_DIFF_LP    3'h2
`define ODGC_FMT_SE_BOTH    3'h4
`define ODGC_FMT_SE_TRUE    3'h5
`define ODGC_FMT_SE_COMP    3'h6

// disabled level codes
`define ODGC_DIS_LOW        2'h0
`define ODGC_DIS_HIGH       2'h1

// forced divide ratio of the output divider
`define ODGC_FORCED_RATIO   2

`endif

// ==== core/odgc_out_div.v ====
// output divider with forced divide-by-2 and an optional final half stage
// assumes src_tick is a one-cycle pulse on ref_clk from the upstream divider
`timescale 1ns/1ns
`include "odgc_defines.vh"

module odgc_out_div #(
   parameter DIV_W = 24
) (
   input  wire             ref_clk,
   input  wire             rst,
   input  wire             src_tick,
   input  wire             force_half,
   input  wire [DIV_W-1:0] divider_value,
   input  wire             bypass,
   output reg              clk_level,
   output reg              edge_tick
);

   reg  [DIV_W-1:0] count;
   reg              bypass_high;
   wire [DIV_W-1:0] last_count;
   wire             stage_done;

   // forced stage end count, one less than the forced ratio, held at the counter width
   localparam [DIV_W-1:0] FORCED_LAST = `ODGC_FORCED_RATIO - 1;

   ////////////////////////////////////////////////////////////////////
   // forced ratio ignores the programmed value; zero is not a forced ratio
   assign last_count = force_half ? FORCED_LAST : divider_value;
   assign stage_done = src_tick && (count >= last_count);

   // divider counter over upstream ticks
   always @(posedge ref_clk) begin
      if (rst) begin
         count       <= {DIV_W{1'b0}};
         clk_level   <= 1'b0;
         bypass_high <= 1'b0;
         edge_tick   <= 1'b0;
      end else begin
         edge_tick <= 1'b0;
         if (src_tick) begin
            if (stage_done) begin
               count <= {DIV_W{1'b0}};
            end else begin
               count <= count + 1'b1;
            end
         end
         if (!bypass) begin
            // final half stage gives a square wave from the counter period
            if (stage_done) begin
               clk_level <= ~clk_level;
               edge_tick <= 1'b1;
            end
         end else if (src_tick) begin
            // bypassed: high for one upstream period, duty set upstream
            bypass_high <= stage_done;
            clk_level   <= stage_done;
            edge_tick   <= stage_done ^ bypass_high;
         end
      end
   end

endmodule

// ==== core/odgc_top.v ====
// clock output driver control: global gate, enable pin, per-output
// powerdown and enable, divider force, half-stage bypass, format and
// disabled level, with synchronous or asynchronous gating
// assumes a byte-wide internal register port from the serial interface,
// upstream divider ticks on ref_clk, and an asynchronous enable pin
`timescale 1ns/1ns
`include "odgc_defines.vh"

module odgc_top #(
   parameter DIV_W = 24
) (
   input  wire             ref_clk,
   input  wire             rst,
   input  wire [15:0]      reg_addr,
   input  wire [7:0]       reg_wdata,
   input  wire             reg_wr,
   input  wire             reg_rd,
   output reg  [7:0]       reg_rdata,
   output reg              reg_rvalid,
   input  wire             output_enable_pin_n,
   input  wire             src_tick,
   input  wire [DIV_W-1:0] output_divider_value,
   output reg              out_true,
   output reg              out_true_oe,
   output reg              out_comp,
   output reg              out_comp_oe,
   output reg              out_weak_pulldown,
   output reg              out_low_power,
   output reg  [3:0]       common_mode_select,
   output reg  [2:0]       diff_amplitude_select,
   output reg  [1:0]       single_ended_drive,
   output reg              out_active
);

   ////////////////////////////////////////////////////////////////////
   // configuration registers
   // one byte each, kept at full width; masked bits simply stay zero
   reg  [7:0] global_output_gate;
   reg  [7:0] output_enable_divider_cfg;
   reg  [7:0] output_format_cfg;
   reg  [7:0] output_amplitude_common_mode;

   // enable pin synchroniser, first stage read only by the second
   reg        pin_meta;
   reg        pin_sync;

   // gate state and divider outputs
   // gate_open holds the gate state; the pin drive process registers it once more before the pins
   reg        gate_open;
   wire       clk_level;
   wire       edge_tick;

   // field views
   wire       global_output_gate_bit;
   wire       driver_powerdown;
   wire       driver_enable;
   wire       divider_force_half;
   wire       half_stage_bypass;
   wire [2:0] driver_format;
   wire       glitchless_gate_select;
   wire [1:0] disabled_level;
   wire       dis_high;
   wire       is_diff;
   wire       want_active;

   ////////////////////////////////////////////////////////////////////
   // true when the format code is one of the two differential modes
   function is_diff_fmt;
      input [2:0] fmt;
      begin
         is_diff_fmt = (fmt == `ODGC_FMT_DIFF) || (fmt == `ODGC_FMT_DIFF_LP);
      end
   endfunction

   ////////////////////////////////////////////////////////////////////
   // register writes; unmapped addresses are ignored
   // unwritable bits are masked on the way in, so reads show them as zero
   // reserved format and disabled codes are kept as written; the decode
   // below decides how they behave, so software reads back what it wrote
   always @(posedge ref_clk) begin
      if (rst) begin
         global_output_gate           <= `ODGC_RST_GATE;
         output_enable_divider_cfg    <= `ODGC_RST_ENDIV;
         output_format_cfg            <= `ODGC_RST_FORMAT;
         output_amplitude_common_mode <= `ODGC_RST_AMPCM;
      end else if (reg_wr) begin
         case (reg_addr)
            `ODGC_ADDR_GATE: begin
               global_output_gate <= reg_wdata & `ODGC_MASK_GATE;
            end
            `ODGC_ADDR_ENDIV: begin
               output_enable_divider_cfg <= reg_wdata & `ODGC_MASK_ENDIV;
            end
            `ODGC_ADDR_FORMAT: begin
               output_format_cfg <= reg_wdata & `ODGC_MASK_FORMAT;
            end
            `ODGC_ADDR_AMPCM: begin
               output_amplitude_common_mode <= reg_wdata & `ODGC_MASK_AMPCM;
            end
            default: begin
               global_output_gate <= global_output_gate;
            end
         endcase
      end
   end

   // register reads, one cycle later; unmapped reads return zero
   // a write and a read in one cycle return the old value, since both
   // processes sample the registers before the write lands
   // reg_rdata holds between reads so a slow master may take it late
   always @(posedge ref_clk) begin
      if (rst) begin
         reg_rdata  <= 8'h00;
         reg_rvalid <= 1'b0;
      end else begin
         reg_rvalid <= reg_rd;
         if (reg_rd) begin
            case (reg_addr)
               `ODGC_ADDR_GATE:   reg_rdata <= global_output_gate;
               `ODGC_ADDR_ENDIV:  reg_rdata <= output_enable_divider_cfg;
               `ODGC_ADDR_FORMAT: reg_rdata <= output_format_cfg;
               `ODGC_ADDR_AMPCM:  reg_rdata <= output_amplitude_common_mode;
               default:           reg_rdata <= 8'h00;
            endcase
         end
      end
   end

   ////////////////////////////////////////////////////////////////////
   // field decode
   // plain slices of the stored bytes; no extra flops, so a field change
   // reaches the gate and pin processes on the very next edge
   assign global_output_gate_bit = global_output_gate[`ODGC_GATE_BIT];
   assign driver_powerdown       = output_enable_divider_cfg[`ODGC_PDN_BIT];
   assign driver_enable          = output_enable_divider_cfg[`ODGC_OE_BIT];
   assign divider_force_half     = output_enable_divider_cfg[`ODGC_FORCE_BIT];
   assign half_stage_bypass      = output_enable_divider_cfg[`ODGC_BYP_BIT];
   assign driver_format          = output_format_cfg[`ODGC_FMT_HI:`ODGC_FMT_LO];
   assign glitchless_gate_select = output_format_cfg[`ODGC_SYNC_BIT];
   assign disabled_level         = output_format_cfg[`ODGC_DIS_HI:`ODGC_DIS_LO];
   // reserved disabled codes fall back to low
   assign dis_high               = (disabled_level == `ODGC_DIS_HIGH);
   assign is_diff                = is_diff_fmt(driver_format);

   // pin comes from the board, so two flops before use; reset as disabled
   // limitation: a pin pulse shorter than one clock may be missed, which is
   // harmless for an enable that a board holds for a long time
   always @(posedge ref_clk) begin
      if (rst) begin
         pin_meta <= 1'b1;
         pin_sync <= 1'b1;
      end else begin
         pin_meta <= output_enable_pin_n;
         pin_sync <= pin_meta;
      end
   end

   // every condition must agree before the output may run
   // the pin flops reset to the disabled level, so a board that holds the
   // pin low still sees the outputs off for the first two cycles
   assign want_active = global_output_gate_bit
                        && !pin_sync
                        && driver_enable
                        && !driver_powerdown;

   ////////////////////////////////////////////////////////////////////
   // output divider with force and half-stage bypass
   // ticks per stage are the programmed value plus one, or two when forced;
   // a programmed zero is a stage of one tick, not a forced two
   // the half stage doubles the period and gives an even duty cycle
   odgc_out_div #(
      .DIV_W         (DIV_W)
   ) u_div (
      .ref_clk       (ref_clk),
      .rst           (rst),
      .src_tick      (src_tick),
      .force_half    (divider_force_half),
      .divider_value (output_divider_value),
      .bypass        (half_stage_bypass),
      .clk_level     (clk_level),
      .edge_tick     (edge_tick)
   );

   ////////////////////////////////////////////////////////////////////
   // gate: asynchronous mode follows at once; glitchless mode only
   // changes while the divided clock sits at the disabled level, so
   // no runt pulse leaves the pin; the cost is up to a half period and one cycle of delay
   // asynchronous mode may cut a high phase short or start mid-phase,
   // which is what software chose when it left the sync bit clear
   // waiting also for a quiet edge keeps the first or last phase full length
   always @(posedge ref_clk) begin
      if (rst) begin
         gate_open <= 1'b0;
      end else if (!glitchless_gate_select) begin
         gate_open <= want_active;
      end else if (want_active != gate_open) begin
         if ((clk_level == dis_high) && !edge_tick) begin
            gate_open <= want_active;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////
   // pin drive from format, gate and disabled level
   // differential: true follows the clock and complement its inverse
   // single-ended both: both pins carry the same clock
   // single-ended true or complement only: the other pin is released
   // disabled outputs sit at the disabled level on every driven pin except the differential complement, which takes its inverse
   // every pin level is registered, so a decode change cannot glitch a pin
   always @(posedge ref_clk) begin
      if (rst) begin
         out_true          <= 1'b0;
         out_true_oe       <= 1'b0;
         out_comp          <= 1'b0;
         out_comp_oe       <= 1'b0;
         out_weak_pulldown <= 1'b1;
         out_active        <= 1'b0;
      end else if (driver_powerdown) begin
         // powered down: both pins float with a weak pull-down
         out_true          <= 1'b0;
         out_true_oe       <= 1'b0;
         out_comp          <= 1'b0;
         out_comp_oe       <= 1'b0;
         out_weak_pulldown <= 1'b1;
         out_active        <= 1'b0;
      end else begin
         out_weak_pulldown <= 1'b0;
         out_active        <= gate_open;
         case (driver_format)
            `ODGC_FMT_DIFF, `ODGC_FMT_DIFF_LP: begin
               out_true    <= gate_open ? clk_level : dis_high;
               out_comp    <= gate_open ? ~clk_level : ~dis_high;
               out_true_oe <= 1'b1;
               out_comp_oe <= 1'b1;
            end
            `ODGC_FMT_SE_BOTH: begin
               out_true    <= gate_open ? clk_level : dis_high;
               out_comp    <= gate_open ? clk_level : dis_high;
               out_true_oe <= 1'b1;
               out_comp_oe <= 1'b1;
            end
            `ODGC_FMT_SE_TRUE: begin
               out_true    <= gate_open ? clk_level : dis_high;
               out_comp    <= 1'b0;
               out_true_oe <= 1'b1;
               out_comp_oe <= 1'b0;
            end
            `ODGC_FMT_SE_COMP: begin
               out_true    <= 1'b0;
               out_comp    <= gate_open ? clk_level : dis_high;
               out_true_oe <= 1'b0;
               out_comp_oe <= 1'b1;
            end
            default: begin
               // reserved formats leave both pins undriven
               out_true    <= 1'b0;
               out_comp    <= 1'b0;
               out_true_oe <= 1'b0;
               out_comp_oe <= 1'b0;
            end
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////
   // analog selects: differential settings only apply in differential modes
   // zero when unused, so the analog side never sees a stale differential
   // setting while the pins run single-ended; drive strength always passes
   always @(posedge ref_clk) begin
      if (rst) begin
         common_mode_select    <= 4'h0;
         diff_amplitude_select <= 3'h0;
         single_ended_drive    <= 2'h0;
         out_low_power         <= 1'b0;
      end else begin
         if (is_diff) begin
            common_mode_select    <= output_amplitude_common_mode[`ODGC_CM_HI:`ODGC_CM_LO];
            diff_amplitude_select <= output_amplitude_common_mode[`ODGC_AMPL_HI:`ODGC_AMPL_LO];
         end else begin
            common_mode_select    <= 4'h0;
            diff_amplitude_select <= 3'h0;
         end
         single_ended_drive <= output_format_cfg[`ODGC_DRV_HI:`ODGC_DRV_LO];
         out_low_power      <= (driver_format == `ODGC_FMT_DIFF_LP);
      end
   end

endmodule

// ==== test/odgc_checker.sv ====
// assertion checker for the clock output driver control top module
// sees only the top module ports; register contents are shadowed from writes
`timescale 1ns/1ns
////////////////////////////////////////////////////////////////////////////////
module odgc_checker (
   input wire logic        ref_clk,
   input wire logic        rst,
   input wire logic [15:0] reg_addr,
   input wire logic [7:0]  reg_wdata,
   input wire logic        reg_wr,
   input wire logic        reg_rd,
   input wire logic [7:0]  reg_rdata,
   input wire logic        reg_rvalid,
   input wire logic        output_enable_pin_n,
   input wire logic        out_true,
   input wire logic        out_true_oe,
   input wire logic        out_comp_oe,
   input wire logic        out_weak_pulldown,
   input wire logic [3:0]  common_mode_select,
   input wire logic [2:0]  diff_amplitude_select,
   input wire logic [1:0]  single_ended_drive,
   input wire logic        out_active
);
   logic [7:0] gate_sh, endiv_sh, fmt_sh, amp_sh, rd_exp;
   logic       diff_fmt, true_ok, comp_ok;
   default clocking @(posedge ref_clk); endclocking
   default disable iff (rst);
   // shadow copies, masked the way the register map stores them
   always @(posedge ref_clk) begin
      if (rst) begin
         gate_sh <= 8'h00;
         endiv_sh <= 8'h00;
         fmt_sh <= 8'h00;
         amp_sh <= 8'h00;
      end else if (reg_wr) begin
         case (reg_addr)
            16'h0102: gate_sh <= reg_wdata & 8'h01;
            16'h0103: endiv_sh <= reg_wdata & 8'h0f;
            16'h0104: fmt_sh <= reg_wdata;
            16'h0105: amp_sh <= reg_wdata & 8'h7f;
            default: ;
         endcase
      end
   end
   // expected read data and which pins each format may drive
   always_comb begin
      case (reg_addr)
         16'h0102: rd_exp = gate_sh;
         16'h0103: rd_exp = endiv_sh;
         16'h0104: rd_exp = fmt_sh;
         16'h0105: rd_exp = amp_sh;
         default: rd_exp = 8'h00;
      endcase
      diff_fmt = (fmt_sh[2:0] == 3'h1) || (fmt_sh[2:0] == 3'h2);
      true_ok = diff_fmt || (fmt_sh[2:0] == 3'h4) || (fmt_sh[2:0] == 3'h5);
      comp_ok = diff_fmt || (fmt_sh[2:0] == 3'h4) || (fmt_sh[2:0] == 3'h6);
   end
   ////////////////////////////////////////////////////////////////////////////
   // sync mode is left out of the gate checks: it may legally wait for a level
   AST_READ_ANSWER: assert property (reg_rd |=> reg_rvalid && reg_rdata == $past(rd_exp))
      else $error("read answer wrong");
   AST_NO_STRAY_VALID: assert property (!reg_rd |=> !reg_rvalid)
      else $error("read valid without read");
   AST_GATE_OFF: assert property ((!gate_sh[0] && !fmt_sh[3])[*3] |-> !out_active)
      else $error("active with gate closed");
   AST_PIN_OFF: assert property ((output_enable_pin_n && !fmt_sh[3])[*5] |-> !out_active)
      else $error("active with enable pin high");
   AST_ACTIVE: assert property ((gate_sh[0] && !output_enable_pin_n && endiv_sh[1:0] == 2'b10 && !fmt_sh[3])[*5]
      |-> out_active) else $error("not active with all enables");
   AST_ENABLE_OFF: assert property ((!endiv_sh[1] && !fmt_sh[3])[*3] |-> !out_active)
      else $error("active with output enable clear");
   AST_POWERDOWN: assert property (endiv_sh[0][*2] |-> out_weak_pulldown && !out_true_oe && !out_comp_oe)
      else $error("powered down driver still drives");
   AST_FORMAT_PINS: assert property ($stable({fmt_sh, endiv_sh})[*3] |->
      out_true_oe == (true_ok && !endiv_sh[0]) && out_comp_oe == (comp_ok && !endiv_sh[0]))
      else $error("pin enables do not match format");
   AST_ANALOG: assert property ($stable({fmt_sh, amp_sh})[*2] |->
      common_mode_select == (diff_fmt ? amp_sh[3:0] : 4'h0) && single_ended_drive == fmt_sh[7:6]
      && diff_amplitude_select == (diff_fmt ? amp_sh[6:4] : 3'h0)) else $error("analog selects wrong");
   AST_DISABLED_LEVEL: assert property ((!gate_sh[0] && !endiv_sh[0] && fmt_sh[3:0] == 4'h1
      && $stable(fmt_sh))[*4] |-> out_true == (fmt_sh[5:4] == 2'h1)) else $error("disabled level wrong");
endmodule

bind odgc_top odgc_checker u_chk (
   .ref_clk(ref_clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
   .reg_rd(reg_rd), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .output_enable_pin_n(output_enable_pin_n),
   .out_true(out_true), .out_true_oe(out_true_oe), .out_comp_oe(out_comp_oe),
   .out_weak_pulldown(out_weak_pulldown), .common_mode_select(common_mode_select),
   .diff_amplitude_select(diff_amplitude_select), .single_ended_drive(single_ended_drive),
   .out_active(out_active)
);

// ==== test/output_driver_gating_control_tb.sv ====
// self-checking bench for the clock output driver control top module
// drives the byte register port, enable pin and divider inputs directly
`timescale 1ns/1ns
////////////////////////////////////////////////////////////////////////////////
module output_driver_gating_control_tb;
   logic        ref_clk = 1'b0;
   logic        rst = 1'b1;
   logic [15:0] reg_addr = 16'h0000;
   logic [7:0]  reg_wdata = 8'h00;
   logic        reg_wr = 1'b0;
   logic        reg_rd = 1'b0;
   logic        output_enable_pin_n = 1'b1;
   logic        src_tick = 1'b1;
   logic [23:0] output_divider_value = 24'h000000;
   wire  [7:0]  reg_rdata, st;
   wire         reg_rvalid, out_true, out_true_oe, out_comp, out_comp_oe, out_weak_pulldown, out_low_power, out_active;
   wire  [3:0]  common_mode_select;
   wire  [2:0]  diff_amplitude_select;
   wire  [1:0]  single_ended_drive;
   int          bad_count = 0;
   int          n_tests = 0;
   int          rises, highs, shorts, n;
   int          fv [7] = '{0, 0, 1, 1, 0, 1, 0};
   int          bv [7] = '{0, 0, 0, 0, 1, 1, 0};
   int          vv [7] = '{0, 2, 2, 5, 3, 3, 2};
   logic        tick_half = 1'b0;
   logic [7:0]  msk [4] = '{8'h01, 8'h0f, 8'hff, 8'h7f};
   // status byte: low power, active, pull-down, true and complement enables
   assign st = {3'h0, out_low_power, out_active, out_weak_pulldown, out_true_oe, out_comp_oe};
   always #4 ref_clk = ~ref_clk;
   // upstream tick every cycle, or every other cycle while tick_half is set
   always @(posedge ref_clk) begin
      #1;
      src_tick = tick_half ? ~src_tick : 1'b1;
   end
   odgc_top dut (
      .ref_clk(ref_clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
      .reg_rd(reg_rd), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .output_enable_pin_n(output_enable_pin_n),
      .src_tick(src_tick), .output_divider_value(output_divider_value), .out_true(out_true),
      .out_true_oe(out_true_oe), .out_comp(out_comp), .out_comp_oe(out_comp_oe),
      .out_weak_pulldown(out_weak_pulldown), .out_low_power(out_low_power),
      .common_mode_select(common_mode_select), .diff_amplitude_select(diff_amplitude_select),
      .single_ended_drive(single_ended_drive), .out_active(out_active));
   ////////////////////////////////////////////////////////////////////////////
   task automatic conclude();
      if (bad_count == 0 && n_tests > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask
   task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
      n_tests++;
      if (got !== exp) begin
         bad_count++;
         $display("FAIL %0t got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic nap(input int c);
      repeat (c) @(posedge ref_clk);
      #1;
   endtask
   // strobes are one cycle wide and change 1 ns after the edge
   task automatic wr(input logic [15:0] a, input logic [7:0] d);
      nap(1);
      reg_addr = a;
      reg_wdata = d;
      reg_wr = 1'b1;
      nap(1);
      reg_wr = 1'b0;
   endtask
   task automatic rd(input logic [15:0] a, input logic [7:0] e);
      nap(1);
      reg_addr = a;
      reg_rd = 1'b1;
      nap(1);
      reg_rd = 1'b0;
      cmp({7'h0, reg_rvalid}, 8'h01);
      cmp(reg_rdata, e);
   endtask
   // counts rising edges, high cycles and one-cycle high pulses over 48 cycles
   task automatic measure();
      int run;
      rises = 0;
      highs = 0;
      shorts = 0;
      run = (out_true === 1'b1) ? 2 : 0; // a high run already under way is no short
      repeat (48) begin
         nap(1);
         if (out_true === 1'b1) begin
            highs++;
            if (run == 0) rises++;
            run++;
         end else begin
            if (run == 1) shorts++;
            run = 0;
         end
      end
   endtask
   ////////////////////////////////////////////////////////////////////////////
   // watchdog: nothing here waits open-ended, but a hang still ends the run
   initial begin
      repeat (20000) @(posedge ref_clk);
      bad_count++;
      conclude();
   end
   initial begin
      nap(6);
      rst = 1'b0;
      for (int i = 0; i < 4; i++) rd(16'h0102 + 16'(i), 8'h00);
      nap(4);
      cmp(st, 8'h00);
      for (int i = 0; i < 4; i++) wr(16'h0102 + 16'(i), 8'hff);
      for (int i = 0; i < 4; i++) rd(16'h0102 + 16'(i), msk[i]);
      wr(16'h0106, 8'hff);
      rd(16'h0106, 8'h00);
      rd(16'h0101, 8'h00);
      // gating chain: gate bit, pin, per-output enable, powerdown
      wr(16'h0102, 8'h00);
      wr(16'h0105, 8'h5a);
      wr(16'h0103, 8'h02);
      wr(16'h0104, 8'h04);
      output_enable_pin_n = 1'b0;
      nap(8);
      cmp(st, 8'h03);
      wr(16'h0102, 8'h01);
      nap(8);
      cmp(st, 8'h0b);
      output_enable_pin_n = 1'b1;
      nap(8);
      cmp(st, 8'h03);
      output_enable_pin_n = 1'b0;
      wr(16'h0103, 8'h00);
      nap(8);
      cmp(st, 8'h03);
      wr(16'h0103, 8'h03);
      nap(8);
      cmp(st, 8'h04);
      wr(16'h0103, 8'h02);
      // every format code, drive field follows the low bits
      for (int f = 0; f < 8; f++) begin
         wr(16'h0104, {f[1:0], 3'h0, f[2:0]});
         nap(8);
         cmp(st, {3'h0, f == 2, 2'b10, f inside {1, 2, 4, 5}, f inside {1, 2, 4, 6}});
         cmp({1'b0, diff_amplitude_select, common_mode_select}, (f == 1 || f == 2) ? 8'h5a : 8'h00);
         cmp({6'h0, single_ended_drive}, {6'h0, f[1:0]});
      end
      // disabled level codes, reserved ones read as low
      wr(16'h0102, 8'h00);
      for (int d = 0; d < 4; d++) begin
         wr(16'h0104, {2'b00, d[1:0], 4'h1});
         nap(8);
         cmp({6'h0, out_true, out_comp}, (d == 1) ? 8'h02 : 8'h01);
      end
      wr(16'h0102, 8'h01);
      wr(16'h0104, 8'h04);
      // divider: force, zero value, ignored value, bypassed half stage
      for (int i = 0; i < 7; i++) begin
         n = ((fv[i] != 0) ? 2 : vv[i] + 1) * ((i == 6) ? 2 : 1);
         tick_half = (i == 6);
         output_divider_value = 24'(vv[i]);
         wr(16'h0103, {4'h0, bv[i][0], fv[i][0], 2'b10});
         nap(16);
         measure();
         cmp(8'(rises), (bv[i] != 0) ? 8'(48 / n) : 8'(24 / n));
         cmp(8'(highs), (bv[i] != 0) ? 8'(48 / n) : 8'h18);
      end
      tick_half = 1'b0;
      // glitchless gating: no runt pulse while the gate closes and reopens,
      // tried at every phase of the divided clock
      wr(16'h0104, 8'h0c);
      wr(16'h0103, 8'h06);
      for (int p = 0; p < 4; p++) begin
         nap(16);
         fork
            measure();
            begin
               nap(10 + p);
               wr(16'h0102, 8'h00);
               nap(8);
               cmp({7'h0, out_true}, 8'h00);
               wr(16'h0102, 8'h01);
            end
         join
         cmp(8'(shorts), 8'h00);
      end
      conclude();
   end
endmodule
